// *** src/cwcs_top.sv ***
// Configuration word decode, start-up clock control and AXI4-Lite registers
// Operation
// - General code protect cleared protects all program memory; set leaves it open.
// - General write protect cleared blocks program memory writes; set allows them.
// - Two-speed start-up runs fast RC first, then switches when source ready.
// - PWM lock at 1 needs key sequence before protected PWM writes; 0 needs none.
// - Select codes 000, 111, 110, 001 pick the fast RC variants.
// - Codes 011, 010 pick primary with or without PLL; 101 low-power RC; 100 reserved.
// - Mode 1x disables switching and monitor; 01 switching only; 00 both.
// - Remap single setting at 1 allows one pin reconfiguration; 0 allows many.
// - Outside crystal modes, second oscillator pin is clock out at 1, I/O at 0.
// - Primary mode 11 off, 10 HS crystal, 01 XT crystal, 00 external clock.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module cwcs_top
  import cwcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire cwcs_cfg_s cfg_word,
  input wire logic src_ready,
  input wire logic clock_fail,
  output logic [2:0] active_src,
  output logic [2:0] target_src,
  output logic primary_osc_enable,
  output logic switch_enable,
  output logic monitor_enable,
  input wire logic prog_read_req,
  output logic prog_read_grant,
  input wire logic prog_write_req,
  output logic prog_write_grant,
  output logic code_protect_active,
  output logic write_protect_active,
  input wire logic pwm_write_req,
  output logic pwm_write_grant,
  input wire logic remap_write_req,
  output logic remap_write_grant,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic gpio_in,
  input wire logic second_oscillator_pin_in,
  output logic second_oscillator_pin_out,
  output logic second_oscillator_pin_oe,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------
  // Decode helpers
  // ----------------
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = a & ADDR_WORD_MASK;
    is_mapped = (w == ADDR_CONFIG) || (w == ADDR_STATUS) ||
                (w == ADDR_CLOCK_SWITCH) || (w == ADDR_PWM_KEY);
  endfunction : is_mapped

  // A source the hardware can really run; reserved or dead primary is refused
  function automatic logic src_usable(input logic [2:0] s, input logic [1:0] posc);
    logic prim;
    prim = (s == SRC_PRIMARY) || (s == SRC_PRIMARY_PLL);
    src_usable = (s != SRC_RESERVED) && !(prim && (posc == POSC_OFF));
  endfunction : src_usable

  // ----------------
  // Configuration capture
  // ----------------
  cwcs_cfg_s cfg;
  cwcs_cfg_s next_cfg;
  logic loaded;
  logic next_loaded;

  always_comb begin
    next_cfg = cfg;
    next_loaded = loaded;
    if (!loaded) begin
      next_cfg = cfg_word;
      next_loaded = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= cwcs_cfg_s'(CFG_SAFE);
      loaded <= 1'b0;
    end else begin
      cfg <= next_cfg;
      loaded <= next_loaded;
    end
  end

  // ----------------
  // Pin synchronisers
  // ----------------
  logic src_ready_s;
  logic clock_fail_s;
  logic pin_in_s;

  cwcs_sync #(.WIDTH(3)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({src_ready, clock_fail, second_oscillator_pin_in}),
    .q({src_ready_s, clock_fail_s, pin_in_s})
  );

  // ----------------
  // Static decode of the caught word
  // ----------------
  logic cfg_error;
  logic [2:0] boot_src;

  always_comb begin
    cfg_error = !src_usable(cfg.oscillator_select, cfg.primary_osc_mode);
    // Bad selections fall back to plain fast RC rather than a dead clock
    boot_src = cfg_error ? SRC_FAST_RC : cfg.oscillator_select;
    switch_enable = loaded && !cfg.clock_switch_monitor_mode[CKSM_DISABLE_BIT];
    monitor_enable = switch_enable && (cfg.clock_switch_monitor_mode != CKSM_SWITCH_ONLY);
    primary_osc_enable = loaded && (cfg.primary_osc_mode != POSC_OFF);
    code_protect_active = !loaded || !cfg.general_code_protect;
    write_protect_active = !loaded || !cfg.general_write_protect;
    prog_read_grant = prog_read_req && !code_protect_active;
    prog_write_grant = prog_write_req && !write_protect_active;
  end

  // ----------------
  // Register bus write path
  // ----------------
  logic wr_fire;
  logic [ADDR_W-1:0] wr_word;
  logic bvalid;
  logic next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic [2:0] req_src;
  logic [2:0] next_req_src;
  logic sw_go;
  logic key_write;
  logic fail_clear;

  always_comb begin
    wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid;
    s_axi_awready = wr_fire;
    s_axi_wready = wr_fire;
    wr_word = s_axi_awaddr & ADDR_WORD_MASK;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_req_src = req_src;
    sw_go = 1'b0;
    key_write = 1'b0;
    fail_clear = 1'b0;
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp = is_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (wr_word == ADDR_CLOCK_SWITCH) begin
        if (s_axi_wstrb[0]) begin
          next_req_src = s_axi_wdata[2:0];
        end
        sw_go = s_axi_wstrb[1] && s_axi_wdata[CLKSW_GO_BIT];
      end
      if (wr_word == ADDR_STATUS) begin
        fail_clear = s_axi_wstrb[0] && s_axi_wdata[STAT_CLOCK_FAIL];
      end
      if (wr_word == ADDR_PWM_KEY) begin
        key_write = (s_axi_wstrb[1:0] == 2'b11);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      req_src <= SRC_FAST_RC;
    end else begin
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      req_src <= next_req_src;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;

  // ----------------
  // Start-up and clock switch sequencer
  // ----------------
  cwcs_state_e state;
  cwcs_state_e next_state;
  logic [2:0] cur_src;
  logic [2:0] next_cur_src;
  logic [2:0] pend_src;
  logic [2:0] next_pend_src;
  logic fail_flag;
  logic next_fail_flag;
  logic fail_event;

  always_comb begin
    next_state = state;
    next_cur_src = cur_src;
    next_pend_src = pend_src;
    fail_event = 1'b0;
    case (state)
      ST_LOAD: begin
        if (loaded) begin
          if (cfg.two_speed_startup_enable && (boot_src != SRC_FAST_RC)) begin
            next_cur_src = SRC_FAST_RC;
            next_pend_src = boot_src;
            next_state = ST_TWO_SPEED;
          end else begin
            next_cur_src = boot_src;
            next_pend_src = boot_src;
            next_state = ST_RUN;
          end
        end
      end
      ST_TWO_SPEED, ST_SWITCH: begin
        if (src_ready_s) begin
          next_cur_src = pend_src;
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (monitor_enable && clock_fail_s && (cur_src != SRC_FAST_RC)) begin
          fail_event = 1'b1;
          next_cur_src = SRC_FAST_RC;
          next_pend_src = SRC_FAST_RC;
        end else if (sw_go && switch_enable && (next_req_src != cur_src) &&
                     src_usable(next_req_src, cfg.primary_osc_mode)) begin
          // Source and go may come in one write
          next_pend_src = next_req_src;
          next_state = ST_SWITCH;
        end
      end
      default: begin
        next_state = ST_LOAD;
      end
    endcase
    // Hardware set wins over a software clear in the same cycle
    next_fail_flag = fail_event || (fail_flag && !fail_clear);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_LOAD;
      cur_src <= SRC_FAST_RC;
      pend_src <= SRC_FAST_RC;
      fail_flag <= 1'b0;
    end else begin
      state <= next_state;
      cur_src <= next_cur_src;
      pend_src <= next_pend_src;
      fail_flag <= next_fail_flag;
    end
  end

  assign active_src = cur_src;
  assign target_src = pend_src;

  // ----------------
  // PWM key lock and pin remap limit
  // ----------------
  logic key_stage;
  logic next_key_stage;
  logic pwm_unlocked;
  logic next_pwm_unlocked;
  logic remap_used;
  logic next_remap_used;

  always_comb begin
    pwm_write_grant = pwm_write_req && loaded &&
                      (!cfg.pwm_register_key_lock || pwm_unlocked);
    remap_write_grant = remap_write_req && loaded &&
                        !(cfg.pin_remap_single_config && remap_used);
    next_key_stage = key_stage;
    next_pwm_unlocked = pwm_unlocked;
    next_remap_used = remap_used || remap_write_grant;
    // One granted write spends the key; a new sequence is needed per write
    if (pwm_write_grant) begin
      next_pwm_unlocked = 1'b0;
    end
    if (key_write) begin
      if (key_stage && (s_axi_wdata[15:0] == PWM_KEY_SECOND)) begin
        next_pwm_unlocked = 1'b1;
        next_key_stage = 1'b0;
      end else begin
        next_key_stage = (s_axi_wdata[15:0] == PWM_KEY_FIRST);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_stage <= 1'b0;
      pwm_unlocked <= 1'b0;
      remap_used <= 1'b0;
    end else begin
      key_stage <= next_key_stage;
      pwm_unlocked <= next_pwm_unlocked;
      remap_used <= next_remap_used;
    end
  end

  // ----------------
  // Second oscillator pin
  // ----------------
  logic clk_toggle;
  logic next_clk_toggle;
  logic pin_out;
  logic next_pin_out;
  logic pin_oe;
  logic next_pin_oe;
  logic crystal_mode;

  always_comb begin
    crystal_mode = (cfg.primary_osc_mode == POSC_XT_CRYSTAL) ||
                   (cfg.primary_osc_mode == POSC_HS_CRYSTAL);
    next_clk_toggle = !clk_toggle;
    if (!loaded || crystal_mode) begin
      // Crystal owns the pin; digital drive would fight the resonator
      next_pin_out = 1'b0;
      next_pin_oe = 1'b0;
    end else if (cfg.osc_pin_function) begin
      next_pin_out = next_clk_toggle;
      next_pin_oe = 1'b1;
    end else begin
      next_pin_out = gpio_out;
      next_pin_oe = gpio_oe;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_toggle <= 1'b0;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      clk_toggle <= next_clk_toggle;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end

  assign second_oscillator_pin_out = pin_out;
  assign second_oscillator_pin_oe = pin_oe;
  assign gpio_in = pin_in_s;

  // ----------------
  // Register bus read path
  // ----------------
  logic rvalid;
  logic next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;
  logic [31:0] status_word;
  logic rd_fire;

  always_comb begin
    status_word = '0;
    status_word[STAT_SRC_LSB +: 3] = cur_src;
    status_word[STAT_TWO_SPEED] = (state == ST_TWO_SPEED);
    status_word[STAT_SWITCH_BUSY] = (state == ST_SWITCH);
    status_word[STAT_CLOCK_FAIL] = fail_flag;
    status_word[STAT_CFG_ERROR] = cfg_error;
    status_word[STAT_REMAP_USED] = remap_used;
    status_word[STAT_PWM_UNLOCKED] = pwm_unlocked;
    status_word[STAT_LOADED] = loaded;
    s_axi_arready = !rvalid;
    rd_fire = s_axi_arvalid && !rvalid;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr & ADDR_WORD_MASK)
        ADDR_CONFIG: next_rdata = {{(32 - CFG_W){1'b0}}, cfg};
        ADDR_STATUS: next_rdata = status_word;
        ADDR_CLOCK_SWITCH: next_rdata = {29'h0000000, req_src};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

endmodule : cwcs_top
`default_nettype wire

// *** src/cwcs_pkg.sv ***
// Package for the configuration word clock select block
package cwcs_pkg;

  // ----------------
  // Configuration word layout
  // ----------------
  typedef struct packed {
    logic general_code_protect;
    logic general_write_protect;
    logic two_speed_startup_enable;
    logic pwm_register_key_lock;
    logic [2:0] oscillator_select;
    logic [1:0] clock_switch_monitor_mode;
    logic pin_remap_single_config;
    logic osc_pin_function;
    logic [1:0] primary_osc_mode;
  } cwcs_cfg_s;

  localparam int CFG_W = $bits(cwcs_cfg_s);
  // Fully protected, plain fast RC: what the logic shows until the word is caught
  localparam logic [CFG_W-1:0] CFG_SAFE = 13'h0000;

  // ----------------
  // Oscillator sources and primary oscillator modes
  // ----------------
  typedef enum logic [2:0] {
    SRC_FAST_RC = 3'b000,
    SRC_FAST_RC_DIVIDE_N_PLL = 3'b001,
    SRC_PRIMARY = 3'b010,
    SRC_PRIMARY_PLL = 3'b011,
    SRC_RESERVED = 3'b100,
    SRC_LOW_POWER_RC = 3'b101,
    SRC_FAST_RC_DIVIDE_16 = 3'b110,
    SRC_FAST_RC_DIVIDE_N = 3'b111
  } cwcs_src_e;

  typedef enum logic [1:0] {
    POSC_EXT_CLOCK = 2'b00,
    POSC_XT_CRYSTAL = 2'b01,
    POSC_HS_CRYSTAL = 2'b10,
    POSC_OFF = 2'b11
  } cwcs_posc_e;

  localparam int CKSM_DISABLE_BIT = 1;
  localparam logic [1:0] CKSM_SWITCH_ONLY = 2'b01;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_TWO_SPEED = 2'b01,
    ST_RUN = 2'b10,
    ST_SWITCH = 2'b11
  } cwcs_state_e;

  // ----------------
  // Register map
  // ----------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_SWITCH = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PWM_KEY = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_WORD_MASK = 8'hFC;

  localparam int STAT_SRC_LSB = 0;
  localparam int STAT_TWO_SPEED = 3;
  localparam int STAT_SWITCH_BUSY = 4;
  localparam int STAT_CLOCK_FAIL = 5;
  localparam int STAT_CFG_ERROR = 6;
  localparam int STAT_REMAP_USED = 7;
  localparam int STAT_PWM_UNLOCKED = 8;
  localparam int STAT_LOADED = 9;
  localparam int CLKSW_GO_BIT = 8;

  localparam logic [15:0] PWM_KEY_FIRST = 16'h4C57;
  localparam logic [15:0] PWM_KEY_SECOND = 16'hABCD;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : cwcs_pkg

// *** src/cwcs_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module cwcs_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // ----------------
  // One chain per bit; first stage feeds only the second
  // ----------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta[i] <= d[i];
        q[i] <= meta[i];
      end
    end
  end
endmodule : cwcs_sync
`default_nettype wire

// *** verification/cwcs_top_sva.sv ***
// Assertion checker for the configuration word clock select block
`timescale 1ns/100ps
`default_nettype none
module cwcs_top_chk
  import cwcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire cwcs_cfg_s cfg_word,
  input wire logic prog_read_req,
  input wire logic prog_read_grant,
  input wire logic prog_write_req,
  input wire logic prog_write_grant,
  input wire logic code_protect_active,
  input wire logic write_protect_active,
  input wire logic switch_enable,
  input wire logic monitor_enable,
  input wire logic primary_osc_enable,
  input wire logic pwm_write_req,
  input wire logic pwm_write_grant,
  input wire logic remap_write_req,
  input wire logic remap_write_grant,
  input wire logic second_oscillator_pin_out,
  input wire logic second_oscillator_pin_oe,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid
);
  logic remap_seen;
  logic next_remap_seen;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----------------
  // Helper: a remap grant has been given since reset
  // ----------------
  always_comb next_remap_seen = remap_seen | remap_write_grant;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remap_seen <= 1'b0;
    end else begin
      remap_seen <= next_remap_seen;
    end
  end
  // ----------------
  // Properties
  // ----------------
  read_grant_a: assert property (prog_read_grant == (prog_read_req && !code_protect_active))
    else $error("read grant disagrees with protection");
  code_prot_a: assert property (!cfg_word.general_code_protect |-> code_protect_active)
    else $error("code protection off while setting clear");
  write_grant_a: assert property (prog_write_grant |-> prog_write_req && !write_protect_active)
    else $error("write granted while protected");
  write_prot_a: assert property (!cfg_word.general_write_protect |-> write_protect_active)
    else $error("write protection off while setting clear");
  pwm_grant_a: assert property (pwm_write_grant |-> pwm_write_req)
    else $error("pwm grant without request");
  switch_gate_a: assert property (switch_enable |-> !cfg_word.clock_switch_monitor_mode[1])
    else $error("switching enabled in disabled mode");
  monitor_gate_a: assert property (monitor_enable |-> switch_enable &&
    cfg_word.clock_switch_monitor_mode == 2'b00) else $error("monitor enabled in wrong mode");
  remap_once_a: assert property (remap_seen && remap_write_grant |->
    !cfg_word.pin_remap_single_config) else $error("second remap granted");
  posc_off_a: assert property (primary_osc_enable |-> cfg_word.primary_osc_mode != 2'b11)
    else $error("primary oscillator on while disabled");
  crystal_pin_a: assert property (cfg_word.primary_osc_mode inside {2'b01, 2'b10} |->
    !second_oscillator_pin_oe) else $error("pin driven in crystal mode");
  clock_out_a: assert property (second_oscillator_pin_oe && cfg_word.osc_pin_function &&
    !(cfg_word.primary_osc_mode inside {2'b01, 2'b10}) |=> $changed(second_oscillator_pin_out))
    else $error("clock output not toggling");
  protect_hold_a: assert property (!($rose(code_protect_active) || $rose(write_protect_active)))
    else $error("protection reasserted without reset");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write response late");
endmodule : cwcs_top_chk

bind cwcs_top cwcs_top_chk i_chk (
  .clk, .rst, .cfg_word, .prog_read_req, .prog_read_grant, .prog_write_req, .prog_write_grant,
  .code_protect_active, .write_protect_active, .switch_enable, .monitor_enable,
  .primary_osc_enable, .pwm_write_req, .pwm_write_grant, .remap_write_req, .remap_write_grant,
  .second_oscillator_pin_out, .second_oscillator_pin_oe, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid
);
`default_nettype wire

// *** verification/config_word_clock_select_test.sv ***
// Self-checking testbench for the configuration word clock select block
`timescale 1ns/100ps
`default_nettype none
module config_word_clock_select_test
  import cwcs_pkg::*;
;
  logic clk = 1'b0;
  logic rst, src_ready, clock_fail, prog_read_req, prog_read_grant, prog_write_req;
  logic prog_write_grant, code_protect_active, write_protect_active, pwm_write_req;
  logic pwm_write_grant, remap_write_req, remap_write_grant, gpio_out, gpio_oe;
  logic primary_osc_enable, switch_enable, monitor_enable, second_oscillator_pin_in;
  logic second_oscillator_pin_out, second_oscillator_pin_oe, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, o1, xtal, gpio_in;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] active_src, target_src;
  logic [3:0] s_axi_wstrb;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, ex;
  cwcs_cfg_s cfg_word, c;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  cwcs_top i_dut (
    .clk, .rst, .cfg_word, .src_ready, .clock_fail, .active_src, .target_src, .primary_osc_enable,
    .switch_enable, .monitor_enable, .prog_read_req, .prog_read_grant, .prog_write_req,
    .prog_write_grant, .code_protect_active, .write_protect_active, .pwm_write_req,
    .pwm_write_grant, .remap_write_req, .remap_write_grant, .gpio_out, .gpio_oe, .gpio_in,
    .second_oscillator_pin_in, .second_oscillator_pin_out, .second_oscillator_pin_oe,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  always #25 clk = ~clk;
  // ----------------
  // Tasks
  // ----------------
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // Whole run is under a thousand cycles; generous ceiling
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exv);
    cmp_count++;
    if (seen !== exv) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exv, seen);
    end
  endtask : check

  function automatic cwcs_cfg_s mk(input logic [3:0] t4, input logic [2:0] os,
    input logic [1:0] ck, input logic [1:0] pins, input logic [1:0] pm);
    return {t4, os, ck, pins, pm};
  endfunction : mk

  // Boot changes config only under reset, as the block samples it once
  task automatic boot(input cwcs_cfg_s cf);
    @(posedge clk);
    cfg_word <= cf;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : boot

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] dt, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge clk); while (!s_axi_bvalid);
    check("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] dt, output logic [1:0] rr);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    dt = s_axi_rdata;
    rr = s_axi_rresp;
  endtask : rd

  task automatic try_req(input logic rm, input logic exv);
    if (rm) remap_write_req <= 1'b1;
    else pwm_write_req <= 1'b1;
    @(negedge clk);
    check(rm ? "remap_grant" : "pwm_grant", 32'(rm ? remap_write_grant : pwm_write_grant), 32'(exv));
    @(posedge clk);
    remap_write_req <= 1'b0;
    pwm_write_req <= 1'b0;
    @(posedge clk);
  endtask : try_req
  // ----------------
  // Tests
  // ----------------
  initial begin
    {src_ready, clock_fail, prog_read_req, prog_write_req, pwm_write_req, remap_write_req} = '0;
    {gpio_out, gpio_oe, second_oscillator_pin_in, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready, rst} = 7'h7F;
    cfg_word = '0;
    for (int i = 0; i < 8; i++) begin
      c = mk(4'hC, i[2:0], 2'b11, 2'b00, 2'b00);
      boot(c);
      ex = (i == 4) ? 32'h240 : 32'h200 | i;
      rd(ADDR_STATUS, d, r);
      check("status", d, ex);
      check("active_src", 32'(active_src), ex & 32'h7);
      rd(ADDR_CONFIG, d, r);
      check("config", d, 32'(c));
    end
    $display("test oscillator select done");
    for (int i = 0; i < 4; i++) begin
      boot(mk({i[1:0], 2'b00}, 3'b000, 2'b11, 2'b00, 2'b00));
      prog_read_req <= 1'b1;
      prog_write_req <= 1'b1;
      @(negedge clk);
      check("read_grant", 32'(prog_read_grant), 32'(i[1]));
      check("code_prot", 32'(code_protect_active), 32'(!i[1]));
      check("write_grant", 32'(prog_write_grant), 32'(i[0]));
      check("write_prot", 32'(write_protect_active), 32'(!i[0]));
      @(posedge clk);
      prog_read_req <= 1'b0;
      prog_write_req <= 1'b0;
    end
    $display("test protection done");
    for (int i = 0; i < 32; i++) begin
      gpio_out <= ~i[0];
      gpio_oe <= i[3];
      second_oscillator_pin_in <= i[0];
      boot(mk(4'hC, 3'b000, i[4:3], {1'b0, i[2]}, i[1:0]));
      @(negedge clk);
      o1 = second_oscillator_pin_out;
      xtal = (i[1:0] == 1) || (i[1:0] == 2);
      check("switch_en", 32'(switch_enable), 32'(!i[4]));
      check("monitor_en", 32'(monitor_enable), 32'(i[4:3] == 0));
      check("posc_en", 32'(primary_osc_enable), 32'(i[1:0] != 3));
      check("pin_oe", 32'(second_oscillator_pin_oe), xtal ? 0 : 32'(i[2] | i[3]));
      check("gpio_in", 32'(gpio_in), 32'(i[0]));
      @(negedge clk);
      check("pin_out", 32'(second_oscillator_pin_out), xtal ? 0 : 32'(i[2] ? !o1 : !i[0]));
    end
    $display("test modes and pin done");
    boot(mk(4'hE, 3'b010, 2'b11, 2'b00, 2'b00));
    rd(ADDR_STATUS, d, r);
    check("two_speed_status", d, 32'h208);
    check("target_src", 32'(target_src), 32'h2);
    src_ready <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("active_src", 32'(active_src), 32'h2);
    @(posedge clk);
    src_ready <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      boot(mk(4'hC, 3'b010, k[1:0], 2'b00, 2'b00));
      clock_fail <= 1'b1;
      repeat (6) @(posedge clk);
      clock_fail <= 1'b0;
      rd(ADDR_STATUS, d, r);
      check("fail_safe", d, k ? 32'h202 : 32'h220);
      if (k == 0) begin
        wr(ADDR_CLOCK_SWITCH, 32'h102, RESP_OKAY);
        src_ready <= 1'b1;
        repeat (5) @(posedge clk);
        src_ready <= 1'b0;
        wr(ADDR_STATUS, 32'h20, RESP_OKAY);
        rd(ADDR_STATUS, d, r);
        check("switch_back", d, 32'h202);
      end
    end
    $display("test start-up and fail-safe done");
    for (int k = 0; k < 2; k++) begin
      c = mk({3'b110, k[0]}, 3'b000, 2'b11, {k[0], 1'b0}, 2'b00);
      boot(c);
      try_req(1'b0, !k[0]);
      if (k == 1) begin
        wr(ADDR_PWM_KEY, {16'h0, PWM_KEY_FIRST}, RESP_OKAY);
        wr(ADDR_PWM_KEY, 32'h1234, RESP_OKAY);
        wr(ADDR_PWM_KEY, {16'h0, PWM_KEY_SECOND}, RESP_OKAY);
        try_req(1'b0, 1'b0);
        wr(ADDR_PWM_KEY, {16'h0, PWM_KEY_FIRST}, RESP_OKAY);
        wr(ADDR_PWM_KEY, {16'h0, PWM_KEY_SECOND}, RESP_OKAY);
      end
      try_req(1'b0, 1'b1);
      try_req(1'b0, !k[0]);
      try_req(1'b1, 1'b1);
      try_req(1'b1, !k[0]);
    end
    $display("test pwm key and remap done");
    wr(ADDR_CONFIG, 32'h0, RESP_OKAY);
    wr(8'h10, 32'hFFFF, RESP_SLVERR);
    rd(8'h10, d, r);
    check("unmapped_data", d, 32'h0);
    check("unmapped_resp", 32'(r), 32'(RESP_SLVERR));
    cfg_word <= mk(4'hE, 3'b101, 2'b11, 2'b10, 2'b00);
    repeat (3) @(posedge clk);
    rd(ADDR_CONFIG, d, r);
    check("config_held", d, 32'(c));
    check("src_held", 32'(active_src), 32'h0);
    $display("test bus and hold done");
    final_report();
  end
endmodule : config_word_clock_select_test
`default_nettype wire
